// *** logic/eeprom_protect_pkg.sv ***
// Purpose: Shared constants, types and decoding for the EEPROM write-protection block
// Assumes: 8-bit address variant, 16-bit words, serial pins oversampled by clk
// Notes: Boundary, flag and lock stand in for non-volatile cells; reset values model a blank part
package eeprom_protect_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W = 6;
    localparam int unsigned HDR_W = 10;

    // Clock counts, start bit included
    localparam logic [CNT_W-1:0] HDR_CLOCKS = 6'h0b;
    localparam logic [CNT_W-1:0] WORD_CLOCKS = 6'h1b;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;

    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_CLEAR = 2'h3;
    localparam logic [1:0] SUB_CLR = 2'h0;
    localparam logic [1:0] SUB_BULK = 2'h1;
    localparam logic [1:0] SUB_SET = 2'h3;
    localparam logic [ADDR_W-1:0] ADDR_ONES = 8'hff;
    localparam logic [ADDR_W-1:0] FREEZE_ADDR = 8'h00;

    localparam logic [ADDR_W-1:0] BOUND_RST = 8'hff;
    localparam logic FLAG_RST = 1'b1;

    typedef enum logic [3:0] {
        I_OTHER = 4'h0, I_WL_SET = 4'h1, I_WL_CLR = 4'h2, I_PROG = 4'h3,
        I_BULK = 4'h4, I_READBACK = 4'h5, I_STORE = 4'h6, I_RESET = 4'h7,
        I_UNLOCK = 4'h8, I_FREEZE = 4'h9
    } instr_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00, PH_FRAME = 2'b01, PH_READOUT = 2'b10
    } phase_t;

    typedef enum logic [1:0] {
        PK_WORD = 2'b00, PK_BULK = 2'b01, PK_BOUNDARY = 2'b10
    } prog_kind_t;

    typedef struct packed {
        logic cs;
        logic sclk;
        logic din;
        logic pre;
        logic wen;
    } serial_pins_t;

    typedef struct packed {
        prog_kind_t kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } prog_req_t;

    typedef struct packed {
        phase_t phase;
        logic sclk_prev;
        logic cs_prev;
        logic [CNT_W-1:0] cnt;
        logic [HDR_W-1:0] hdr;
        logic [DATA_W-1:0] data;
        logic wl;
        logic unlock;
        logic [ADDR_W-1:0] bound;
        logic flag;
        logic lock;
        logic busy;
        logic status;
        logic [ADDR_W:0] rd_shift;
        logic rd_bit;
        logic q;
        logic q_oe;
        logic prog_start;
        prog_req_t req;
    } state_t;

    localparam state_t STATE_RST = '{
        phase: PH_IDLE,
        bound: BOUND_RST,
        flag: FLAG_RST,
        req: '{kind: PK_WORD, default: '0},
        default: '0
    };

    function automatic instr_t decode(input logic [HDR_W-1:0] hdr, input logic pre);
        logic [1:0] op;
        logic [ADDR_W-1:0] a;
        op = hdr[9:8];
        a = hdr[7:0];
        decode = I_OTHER;
        if (pre)
        begin
            if (op == OP_READ)
                decode = I_READBACK;
            else if (op == OP_WRITE)
                decode = I_STORE;
            else if (op == OP_CLEAR && a == ADDR_ONES)
                decode = I_RESET;
            else if (op == OP_EXT && a[7:6] == SUB_SET)
                decode = I_UNLOCK;
            else if (op == OP_EXT && a == FREEZE_ADDR)
                decode = I_FREEZE;
        end
        else
        begin
            if (op == OP_WRITE)
                decode = I_PROG;
            else if (op == OP_EXT && a[7:6] == SUB_SET)
                decode = I_WL_SET;
            else if (op == OP_EXT && a[7:6] == SUB_CLR)
                decode = I_WL_CLR;
            else if (op == OP_EXT && a[7:6] == SUB_BULK)
                decode = I_BULK;
        end
    endfunction : decode

endpackage : eeprom_protect_pkg

// *** logic/pin_sync.sv ***
// Purpose: Two-or-more flop synchroniser for the serial pins
// Assumes: Pins are asynchronous to clk
// Notes: Only the last stage leaves the module
`timescale 1ns/1ns
module pin_sync import eeprom_protect_pkg::*; #(
    parameter int unsigned STAGES = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pins
    input wire serial_pins_t pins_in,
    output serial_pins_t pins_out
);
    localparam int unsigned W = $bits(serial_pins_t);

    if (STAGES < 2)
    begin : g_bad_stages
        $error("pin_sync needs at least two stages");
    end

    logic [STAGES-1:0][W-1:0] chain_q;
    logic [STAGES-1:0][W-1:0] chain_d;

    always_comb
    begin
        chain_d = {chain_q[STAGES-2:0], pins_in};
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            chain_q <= '0;
        else
            chain_q <= chain_d;
    end

    assign pins_out = chain_q[STAGES-1];

endmodule : pin_sync

// *** logic/boundary_gate.sv ***
// Purpose: Address check of a program target against the protection boundary
// Assumes: Boundary and flag come from registers
// Notes: Purely combinational
`timescale 1ns/1ns
module boundary_gate import eeprom_protect_pkg::*; (
    // Target
    input wire logic [ADDR_W-1:0] addr,
    // Protection state
    input wire logic [ADDR_W-1:0] bound,
    input wire logic flag,
    // Result
    output logic blocked
);
    // Flag 1 means no boundary protection at all
    assign blocked = ~flag && (addr >= bound);

endmodule : boundary_gate

// *** logic/serial_eeprom_write_protect.sv ***
// Purpose: Instruction sequencing and write protection of a serial 16-bit EEPROM
// Assumes: Serial pins oversampled by clk; array reports completion on prog_done
// Notes: Serial clock must be well below clk/4 so every edge is seen
`timescale 1ns/1ns
module serial_eeprom_write_protect import eeprom_protect_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Serial bus pins, asynchronous
    input wire serial_pins_t pins,
    output logic dout,
    output logic dout_oe,
    // Memory array side
    output logic prog_start,
    output prog_req_t prog_req,
    input wire logic prog_done,
    // Protection status
    output logic [ADDR_W-1:0] boundary,
    output logic protect_flag,
    output logic lock_set,
    output logic busy
);
    serial_pins_t s;
    state_t st_q;
    state_t st_d;
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;
    logic addr_blocked;
    logic mod_ok;
    logic [HDR_W-1:0] hdr_next;
    instr_t instr;

    // Field slicing and decoding assume these counts; anything else misframes
    if (ADDR_W != 8)
    begin : g_bad_addr
        $error("decoder and constants assume an eight-bit address");
    end

    if (HDR_W != ADDR_W + 2)
    begin : g_bad_hdr
        $error("header width must be op-code plus address");
    end

    if (HDR_CLOCKS != HDR_W + 1)
    begin : g_bad_start
        $error("header count must be header bits plus start bit");
    end

    if (WORD_CLOCKS != HDR_CLOCKS + DATA_W)
    begin : g_bad_word
        $error("word count must be header count plus data bits");
    end

    if (CNT_MAX <= WORD_CLOCKS)
    begin : g_bad_sat
        $error("clock counter too narrow to saturate above a word frame");
    end

    pin_sync #(.STAGES(2)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pins_in(pins),
        .pins_out(s)
    );

    boundary_gate u_gate (
        .addr(st_q.hdr[7:0]),
        .bound(st_q.bound),
        .flag(st_q.flag),
        .blocked(addr_blocked)
    );

    assign sclk_rise = s.sclk & ~st_q.sclk_prev;
    assign cs_fall = ~s.cs & st_q.cs_prev;
    assign cs_rise = s.cs & ~st_q.cs_prev;
    assign hdr_next = {st_q.hdr[HDR_W-2:0], s.din};
    assign instr = (st_q.cnt >= HDR_CLOCKS) ? decode(st_q.hdr, s.pre) : I_OTHER;
    assign mod_ok = st_q.unlock & st_q.wl & s.pre & s.wen & ~st_q.lock;

    always_comb
    begin
        st_d = st_q;
        st_d.prog_start = 1'b0;
        st_d.sclk_prev = s.sclk;
        st_d.cs_prev = s.cs;
        if (st_q.busy && prog_done)
            st_d.busy = 1'b0;
        // Status shows only when chip select rises into a busy cycle
        if (cs_rise && st_q.busy)
            st_d.status = 1'b1;
        if (!s.cs)
            st_d.status = 1'b0;
        // Bus is ignored while a program cycle runs
        if (s.cs && sclk_rise && !st_q.busy)
        begin
            case (st_q.phase)
                PH_IDLE:
                begin
                    if (s.din)
                    begin
                        st_d.phase = PH_FRAME;
                        st_d.cnt = 6'h01;
                        st_d.hdr = '0;
                        st_d.data = '0;
                        st_d.status = 1'b0;
                    end
                end
                PH_FRAME, PH_READOUT:
                begin
                    // Saturate so long noisy frames never wrap to a valid count
                    if (st_q.cnt != CNT_MAX)
                        st_d.cnt = st_q.cnt + 6'h01;
                    if (st_q.cnt < HDR_CLOCKS)
                        st_d.hdr = hdr_next;
                    else if (st_q.cnt < WORD_CLOCKS)
                        st_d.data = {st_q.data[DATA_W-2:0], s.din};
                    if (st_q.phase == PH_READOUT)
                    begin
                        st_d.rd_bit = st_q.rd_shift[ADDR_W];
                        st_d.rd_shift = {st_q.rd_shift[ADDR_W-1:0], 1'b0};
                    end
                    else if (st_q.cnt == HDR_CLOCKS - 6'h01 && s.pre
                             && hdr_next[9:8] == OP_READ)
                    begin
                        st_d.phase = PH_READOUT;
                        st_d.rd_bit = 1'b0;
                        st_d.rd_shift = {st_q.bound, st_q.flag};
                    end
                end
                default:
                    st_d.phase = PH_IDLE;
            endcase
        end
        if (cs_fall && st_q.phase != PH_IDLE)
        begin
            st_d.phase = PH_IDLE;
            st_d.unlock = 1'b0;
            case (instr)
                I_WL_SET:
                    st_d.wl = 1'b1;
                I_WL_CLR:
                    st_d.wl = 1'b0;
                I_UNLOCK:
                begin
                    // Flag left alone on purpose
                    if (st_q.wl && s.pre && s.wen)
                        st_d.unlock = 1'b1;
                end
                I_STORE:
                begin
                    if (mod_ok && st_q.cnt == HDR_CLOCKS)
                    begin
                        st_d.bound = st_q.hdr[7:0];
                        st_d.flag = 1'b0;
                        st_d.prog_start = 1'b1;
                        st_d.busy = 1'b1;
                        st_d.req = '{kind: PK_BOUNDARY, addr: st_q.hdr[7:0], data: '0};
                    end
                end
                I_RESET:
                begin
                    if (mod_ok && st_q.cnt == HDR_CLOCKS)
                    begin
                        st_d.bound = ADDR_ONES;
                        st_d.flag = 1'b1;
                        st_d.prog_start = 1'b1;
                        st_d.busy = 1'b1;
                        st_d.req = '{kind: PK_BOUNDARY, addr: ADDR_ONES, data: '0};
                    end
                end
                I_FREEZE:
                begin
                    if (mod_ok)
                    begin
                        st_d.lock = 1'b1;
                        st_d.prog_start = 1'b1;
                        st_d.busy = 1'b1;
                        st_d.req = '{kind: PK_BOUNDARY, addr: st_q.bound, data: '0};
                    end
                end
                I_PROG:
                begin
                    if (st_q.wl && s.wen && st_q.cnt == WORD_CLOCKS
                        && !addr_blocked)
                    begin
                        st_d.prog_start = 1'b1;
                        st_d.busy = 1'b1;
                        st_d.req = '{kind: PK_WORD, addr: st_q.hdr[7:0], data: st_q.data};
                    end
                end
                I_BULK:
                begin
                    // Whole-array write only with boundary protection cleared
                    if (st_q.wl && s.wen && st_q.cnt == WORD_CLOCKS && st_q.flag)
                    begin
                        st_d.prog_start = 1'b1;
                        st_d.busy = 1'b1;
                        st_d.req = '{kind: PK_BULK, addr: '0, data: st_q.data};
                    end
                end
                default:
                    st_d.unlock = 1'b0;
            endcase
        end
        st_d.q_oe = s.cs && ((st_d.phase == PH_READOUT)
                             || (st_d.status && !st_d.lock));
        st_d.q = (st_d.phase == PH_READOUT) ? st_d.rd_bit : ~st_d.busy;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            st_q <= STATE_RST;
        else
            st_q <= st_d;
    end

    assign dout = st_q.q;
    assign dout_oe = st_q.q_oe;
    assign prog_start = st_q.prog_start;
    assign prog_req = st_q.req;
    assign boundary = st_q.bound;
    assign protect_flag = st_q.flag;
    assign lock_set = st_q.lock;
    assign busy = st_q.busy;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Protection register changes
    a_bound_needs_unlock: assert property (
        $changed(st_q.bound) |-> $past(st_q.unlock))
        else $error("boundary changed without unlock");
    a_lock_freezes_bound: assert property (
        $past(st_q.lock) |-> $stable(st_q.bound))
        else $error("boundary changed while locked");
    a_reset_loads_ones: assert property (
        cs_fall && st_q.phase != PH_IDLE && instr == I_RESET && mod_ok && st_q.cnt == 6'h0b
        |=> st_q.bound == 8'hff && st_q.flag)
        else $error("boundary reset did not load ones and flag");
    a_store_clears_flag: assert property (
        cs_fall && st_q.phase != PH_IDLE && instr == I_STORE && mod_ok && st_q.cnt == 6'h0b
        |=> !st_q.flag && st_q.bound == $past(st_q.hdr[7:0]))
        else $error("boundary store wrong");
    a_unlock_keeps_flag: assert property (
        cs_fall && instr == I_UNLOCK |=> $stable(st_q.flag))
        else $error("unlock changed flag");
    a_unlock_needs_latch: assert property ($rose(st_q.unlock) |-> $past(st_q.wl))
        else $error("unlock granted with write latch clear");
    a_flag_needs_unlock: assert property (
        $changed(st_q.flag) |-> $past(st_q.unlock))
        else $error("flag changed without unlock");
    a_freeze_sets_lock: assert property (
        cs_fall && st_q.phase != PH_IDLE && instr == I_FREEZE && mod_ok
        |=> st_q.lock)
        else $error("freeze did not set lock");
    a_lock_sticks: assert property (st_q.lock |=> st_q.lock)
        else $error("lock bit cleared");
    a_unlock_cancelled: assert property (
        cs_fall && st_q.phase != PH_IDLE && instr != I_UNLOCK |=> !st_q.unlock)
        else $error("unlock survived another instruction");

    // Program launches
    a_word_count_27: assert property (
        st_q.prog_start && st_q.req.kind == PK_WORD |-> $past(st_q.cnt) == 6'h1b)
        else $error("word program launched with wrong clock count");
    a_boundary_count: assert property (
        st_q.prog_start && st_q.req.kind == PK_BOUNDARY && !st_q.lock
        |-> $past(st_q.cnt) == 6'h0b)
        else $error("boundary program launched with wrong clock count");
    a_bulk_guarded: assert property (
        st_q.prog_start && st_q.req.kind == PK_BULK
        |-> $past(st_q.flag) && $past(st_q.cnt) == 6'h1b)
        else $error("bulk program launched while protected or miscounted");
    a_prog_needs_latch: assert property (st_q.prog_start |-> $past(st_q.wl))
        else $error("program launched with write latch clear");
    a_prog_outside_bound: assert property (
        st_q.prog_start && st_q.req.kind == PK_WORD
        |-> $past(st_q.flag) || st_q.req.addr < $past(st_q.bound))
        else $error("program launched into protected area");
    a_start_sets_busy: assert property (st_q.prog_start |-> st_q.busy)
        else $error("program launched without busy");
    a_busy_holds_idle: assert property (st_q.busy |-> st_q.phase == PH_IDLE)
        else $error("frame advanced during a program cycle");

    // Serial data out
    a_lock_hides_status: assert property (st_q.lock && st_q.phase == PH_IDLE |-> !dout_oe)
        else $error("status shown while locked");
    a_busy_drives_low: assert property (
        st_q.busy && !prog_done && st_q.status && !st_q.lock && s.cs && $stable(s.cs)
        |=> dout_oe && !dout)
        else $error("busy status not driven low");
    a_ready_drives_high: assert property (
        st_q.status && !st_q.busy && !st_q.lock && s.cs && !sclk_rise
        |=> dout_oe && dout)
        else $error("ready status not driven high");
    a_readback_dummy: assert property (
        $past(st_q.phase) == PH_FRAME && st_q.phase == PH_READOUT
        |-> !st_q.rd_bit && st_q.rd_shift == {$past(st_q.bound), $past(st_q.flag)})
        else $error("readback did not start with dummy zero");
    a_readout_shifts: assert property (
        $past(st_q.phase == PH_READOUT && s.cs && sclk_rise && !st_q.busy)
        && st_q.phase == PH_READOUT
        |-> st_q.rd_bit == $past(st_q.rd_shift[ADDR_W]))
        else $error("readback bit out of order");

    c_store: cover property (st_q.prog_start && st_q.req.kind == PK_BOUNDARY && !st_q.flag);
    c_reset: cover property ($rose(st_q.flag));
    c_freeze: cover property ($rose(st_q.lock));
    c_readback: cover property ($rose(st_q.phase == PH_READOUT));
    c_bulk: cover property (st_q.prog_start && st_q.req.kind == PK_BULK);

endmodule : serial_eeprom_write_protect

// *** test/array_model.sv ***
// Purpose: Memory array stand-in that answers program cycles after a fixed delay
// Assumes: Same clock as the protection block; prog_start is a one-cycle pulse
// Notes: Counts starts and keeps the last request so the bench can judge gating
`timescale 1ns/1ns
module array_model import eeprom_protect_pkg::*; #(
    parameter int unsigned DELAY = 300
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Program request
    input wire logic prog_start,
    input wire prog_req_t prog_req,
    output logic prog_done,
    // Observation
    output logic [15:0] n_start,
    output prog_req_t last_req
);
    int unsigned left_q;

    // Done is a single pulse, so a design that waits for a level would hang
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prog_done <= 1'b0;
            n_start <= 16'h0000;
            last_req <= '0;
            left_q <= 0;
        end
        else
        begin
            prog_done <= 1'b0;
            if (prog_start)
            begin
                n_start <= n_start + 16'h0001;
                last_req <= prog_req;
                left_q <= DELAY;
            end
            else if (left_q == 1)
            begin
                prog_done <= 1'b1;
                left_q <= 0;
            end
            else if (left_q != 0)
                left_q <= left_q - 1;
        end
    end
endmodule : array_model

// *** test/serial_eeprom_write_protect_tb.sv ***
// Purpose: Self-checking bench for the EEPROM write-protection block
// Assumes: Serial clock 16 clk per bit, pins changed on falling clk edges
// Notes: Master side is the xfer task; array side is array_model
`timescale 1ns/1ns
module serial_eeprom_write_protect_tb import eeprom_protect_pkg::*;;
    logic clk, reset_n, dout, dout_oe, prog_start, prog_done, protect_flag, lock_set, busy;
    serial_pins_t pins;
    prog_req_t prog_req, last_req;
    logic [ADDR_W-1:0] boundary;
    logic [15:0] n_start, s0;
    logic [31:0] rd;
    int n_mismatch, compares;

    serial_eeprom_write_protect DUT (.clk(clk), .reset_n(reset_n), .pins(pins), .dout(dout),
        .dout_oe(dout_oe), .prog_start(prog_start), .prog_req(prog_req),
        .prog_done(prog_done), .boundary(boundary), .protect_flag(protect_flag),
        .lock_set(lock_set), .busy(busy));
    array_model #(.DELAY(300)) partner (.clk(clk), .reset_n(reset_n),
        .prog_start(prog_start), .prog_req(prog_req), .prog_done(prog_done),
        .n_start(n_start), .last_req(last_req));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task automatic ended(input string name);
        $display("test %s finished", name);
    endtask : ended

    // Dout is sampled just before each rise, so bit k shows what rise k-1 launched
    task automatic xfer(input logic pre, input logic wen, input int n, input logic [31:0] bits);
        rd = '0;
        pins.cs = 1'b1;
        pins.pre = pre;
        pins.wen = wen;
        for (int i = n - 1; i >= 0; i--)
        begin
            pins.din = bits[i];
            repeat (8) @(negedge clk);
            rd = {rd[30:0], dout};
            pins.sclk = 1'b1;
            repeat (8) @(negedge clk);
            pins.sclk = 1'b0;
        end
        repeat (8) @(negedge clk);
        pins.cs = 1'b0;
        repeat (8) @(negedge clk);
    endtask : xfer

    task automatic idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 2000)
        begin
            @(negedge clk);
            k++;
        end
        if (k >= 2000)
            chk(32'h0, 32'h1);
    endtask : idle

    task automatic hdr(input logic pre, input logic [1:0] op, input logic [7:0] a);
        xfer(pre, 1'b1, 11, {21'h0, 1'b1, op, a});
        idle();
    endtask : hdr

    task automatic prog(input logic [7:0] a, input logic [15:0] d);
        xfer(1'b0, 1'b1, 27, {5'h00, 1'b1, OP_WRITE, a, d});
        idle();
    endtask : prog

    task automatic readback();
        xfer(1'b1, 1'b1, 21, {11'h000, 1'b1, OP_READ, 8'h00, 10'h000});
        idle();
    endtask : readback

    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        test_done();
    end

    initial
    begin
        pins = '0;
        reset_n = 1'b0;
        n_mismatch = 0;
        compares = 0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(boundary, 8'hff);
        chk({protect_flag, lock_set, busy, dout_oe}, 4'h8);
        ended("reset");
        s0 = n_start;
        prog(8'h10, 16'h1234);
        chk(n_start, s0);
        hdr(1'b0, OP_EXT, 8'hc0);
        prog(8'h10, 16'ha5c3);
        chk(n_start, s0 + 16'h1);
        chk(last_req, {PK_WORD, 8'h10, 16'ha5c3});
        for (int n = 26; n <= 28; n += 2)
        begin
            s0 = n_start;
            xfer(1'b0, 1'b1, n, (n < 27) ? 32'h0511_0f0f >> 1 : 32'h0511_0f0f << 1);
            idle();
            chk(n_start, s0);
        end
        ended("word_program");
        hdr(1'b1, OP_WRITE, 8'h80);
        chk(boundary, 8'hff);
        hdr(1'b1, OP_EXT, 8'hc0);
        chk(protect_flag, 1'b1);
        readback();
        chk(rd[9:0], {1'b0, 8'hff, 1'b1});
        hdr(1'b1, OP_WRITE, 8'h80);
        chk(boundary, 8'hff);
        xfer(1'b1, 1'b0, 11, {21'h0, 1'b1, OP_EXT, 8'hc0});
        hdr(1'b1, OP_WRITE, 8'h80);
        chk(boundary, 8'hff);
        hdr(1'b1, OP_EXT, 8'hc0);
        hdr(1'b1, OP_WRITE, 8'h80);
        chk({boundary, protect_flag}, {8'h80, 1'b0});
        chk(last_req, {PK_BOUNDARY, 8'h80, 16'h0000});
        readback();
        chk(rd[9:0], {1'b0, 8'h80, 1'b0});
        ended("boundary_store");
        s0 = n_start;
        prog(8'h80, 16'h0001);
        prog(8'hff, 16'h0002);
        chk(n_start, s0);
        prog(8'h7f, 16'h0003);
        chk(n_start, s0 + 16'h1);
        xfer(1'b0, 1'b1, 27, {5'h00, 1'b1, OP_EXT, 8'h40, 16'hbeef});
        idle();
        chk(n_start, s0 + 16'h1);
        xfer(1'b0, 1'b1, 27, {5'h00, 1'b1, OP_WRITE, 8'h20, 16'h5555});
        pins.cs = 1'b1;
        repeat (10) @(negedge clk);
        chk({dout_oe, dout}, 2'b10);
        idle();
        repeat (6) @(negedge clk);
        chk({dout_oe, dout}, 2'b11);
        pins.cs = 1'b0;
        repeat (8) @(negedge clk);
        ended("gating_status");
        hdr(1'b1, OP_EXT, 8'hc0);
        hdr(1'b1, OP_CLEAR, 8'hff);
        chk({boundary, protect_flag}, {8'hff, 1'b1});
        s0 = n_start;
        prog(8'hff, 16'h00ff);
        chk(n_start, s0 + 16'h1);
        hdr(1'b1, OP_EXT, 8'hc0);
        xfer(1'b1, 1'b1, 12, {20'h0, 1'b1, OP_WRITE, 8'h40, 1'b0});
        idle();
        chk(boundary, 8'hff);
        hdr(1'b0, OP_EXT, 8'h00);
        s0 = n_start;
        prog(8'h30, 16'h0bad);
        chk(n_start, s0);
        hdr(1'b0, OP_EXT, 8'hc0);
        s0 = n_start;
        xfer(1'b0, 1'b1, 27, {5'h00, 1'b1, OP_EXT, 8'h40, 16'hbeef});
        idle();
        chk(n_start, s0 + 16'h1);
        chk(last_req, {PK_BULK, 8'h00, 16'hbeef});
        ended("boundary_reset");
        hdr(1'b1, OP_EXT, 8'hc0);
        hdr(1'b1, OP_EXT, FREEZE_ADDR);
        chk(lock_set, 1'b1);
        readback();
        hdr(1'b1, OP_EXT, 8'hc0);
        s0 = n_start;
        hdr(1'b1, OP_WRITE, rd[8:1]);
        hdr(1'b1, OP_EXT, 8'hc0);
        hdr(1'b1, OP_WRITE, 8'h20);
        chk({boundary, n_start}, {8'hff, s0});
        xfer(1'b0, 1'b1, 27, {5'h00, 1'b1, OP_WRITE, 8'h05, 16'h1111});
        pins.cs = 1'b1;
        repeat (10) @(negedge clk);
        chk({busy, dout_oe}, 2'b10);
        idle();
        pins.cs = 1'b0;
        repeat (8) @(negedge clk);
        ended("freeze");
        test_done();
    end
endmodule : serial_eeprom_write_protect_tb
